// ==== rtl/safety_diag_pkg.sv ====
package safety_diag_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 6;
    localparam int CFG_W  = 8;
    localparam int SPI_W  = 8;
    localparam int OFF_W  = 8;
    localparam int WDS_W  = 8;

    // register indices of the access port
    localparam logic [ADDR_W-1:0] ADDR_ERR_STAT4    = 6'h00;
    localparam logic [ADDR_W-1:0] ADDR_SPI_XFER     = 6'h01;
    localparam logic [ADDR_W-1:0] ADDR_ANALOG_SELF_TEST_CTRL   = 6'h02;
    localparam logic [ADDR_W-1:0] ADDR_LOGIC_SELF_TEST_CTRL   = 6'h03;
    localparam logic [ADDR_W-1:0] ADDR_CHECK_CTRL   = 6'h04;
    localparam logic [ADDR_W-1:0] ADDR_PWM_HMAX     = 6'h05;
    localparam logic [ADDR_W-1:0] ADDR_PWM_HMIN     = 6'h06;
    localparam logic [ADDR_W-1:0] ADDR_PWM_LMAX     = 6'h07;
    localparam logic [ADDR_W-1:0] ADDR_PWM_LMIN     = 6'h08;
    localparam logic [ADDR_W-1:0] ADDR_PWD_TH       = 6'h09;
    localparam logic [ADDR_W-1:0] ADDR_CFG_CRC      = 6'h0A;
    localparam logic [ADDR_W-1:0] ADDR_DIAG_CTRL    = 6'h0B;
    localparam logic [ADDR_W-1:0] ADDR_DIAG_MUX     = 6'h0C;
    localparam logic [ADDR_W-1:0] ADDR_WDT_WIN1     = 6'h0D;
    localparam logic [ADDR_W-1:0] ADDR_WDT_WIN2     = 6'h0E;
    localparam logic [ADDR_W-1:0] ADDR_WDT_QA_CFG   = 6'h0F;
    localparam logic [ADDR_W-1:0] ADDR_WDT_QUESTION = 6'h10;
    localparam logic [ADDR_W-1:0] ADDR_WDT_STATUS   = 6'h11;
    localparam logic [ADDR_W-1:0] ADDR_WDT_ANSWER   = 6'h12;
    localparam logic [ADDR_W-1:0] ADDR_OFF_STAT     = 6'h13;

    // field layout of the fourth error status register
    localparam int DEVICE_ERROR_COUNTER_LSB = 0;
    localparam int DEVICE_ERROR_COUNTER_W   = 4;
    localparam int DIAG_TO_BIT     = 4;

    // values after reset or reinitialisation
    localparam logic [DATA_W-1:0] CTRL_INIT     = 8'h00;
    localparam logic [DATA_W-1:0] WIN1_INIT     = 8'h00;
    localparam logic [DATA_W-1:0] WIN2_INIT     = 8'h00;
    localparam logic [DATA_W-1:0] QA_CFG_INIT   = 8'h00;
    localparam logic [DATA_W-1:0] QUESTION_INIT = 8'h00;
    localparam logic [DATA_W-1:0] ANSWER_INIT   = 8'h00;
    localparam logic [DATA_W-1:0] UNMAPPED_VAL  = 8'h00;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } spi_req_s;

    typedef struct packed {
        logic config_lock_bit;
        logic control_lock_bit;
        logic selftest_lock_bit;
        logic diag_state;
    } lock_s;

    typedef struct packed {
        logic [DATA_W-1:0] analog_self_test_ctrl;
        logic [DATA_W-1:0] logic_self_test_ctrl;
        logic [DATA_W-1:0] check_ctrl;
        logic [DATA_W-1:0] diag_ctrl;
        logic [DATA_W-1:0] diag_mux_sel;
        logic [DATA_W-1:0] pwm_hmax;
        logic [DATA_W-1:0] pwm_hmin;
        logic [DATA_W-1:0] pwm_lmax;
        logic [DATA_W-1:0] pwm_lmin;
        logic [DATA_W-1:0] pwd_th;
        logic [DATA_W-1:0] configuration_checksum;
        logic [DATA_W-1:0] wdt_win1;
        logic [DATA_W-1:0] wdt_win2;
        logic [DATA_W-1:0] wdt_qa_cfg;
    } ctrl_s;

endpackage

// ==== rtl/sticky_flags.sv ====
`timescale 1ns/1ps
module sticky_flags
    import safety_diag_pkg::*;
#(
    parameter int W = 8
)(
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         init,
    input  wire logic         rd_clr,
    input  wire logic [W-1:0] cond,
    output logic      [W-1:0] flags
);
    logic [W-1:0] flags_q;
    logic [W-1:0] flags_d;

    for (genvar i = 0; i < W; i++)
    begin : g_bit
        always_comb
        begin
            // a set in the clearing cycle wins; a read only drops a bit whose cause is gone
            if (init)
                flags_d[i] = 1'b0;
            else if (cond[i])
                flags_d[i] = 1'b1;
            else if (rd_clr)
                flags_d[i] = 1'b0;
            else
                flags_d[i] = flags_q[i];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_q <= '0;
        else if (ce)
            flags_q <= flags_d;
    end

    assign flags = flags_q;

endmodule // sticky_flags

// ==== rtl/safety_diag_regs.sv ====
`timescale 1ns/1ps
module safety_diag_regs
    import safety_diag_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire spi_req_s                 req,
    input  wire lock_s                    locks,
    input  wire logic                     device_reset,
    input  wire logic                     logic_self_test_run,
    input  wire logic [CFG_W-1:0]         watchdog_config,
    input  wire logic                     diag_timeout_cond,
    input  wire logic [2:0]               err4_live,
    input  wire logic                     dev_err_inc,
    input  wire logic                     spi_frame_done,
    input  wire logic [SPI_W-1:0]         spi_frame_err,
    input  wire logic [OFF_W-1:0]         off_state_cond,
    input  wire logic                     wd_question_load,
    input  wire logic [DATA_W-1:0]        wd_question_in,
    input  wire logic [WDS_W-1:0]         wd_status_in,
    output logic      [DATA_W-1:0]        rd_data,
    output logic                          rd_valid,
    output logic                          wr_refused,
    output ctrl_s                         ctrl,
    output logic      [DEVICE_ERROR_COUNTER_W-1:0] device_error_counter,
    output logic      [DATA_W-1:0]        wdt_answer,
    output logic                          wdt_answer_stb,
    output logic                          wd_reinit,
    output logic                          cfg_checksum_bad
);

    function automatic logic write_allowed(input logic [ADDR_W-1:0] a, input lock_s l);
        logic cfg_ok;
        cfg_ok = l.diag_state && !l.config_lock_bit;
        unique case (a)
            ADDR_ERR_STAT4:                   write_allowed = cfg_ok;
            ADDR_ANALOG_SELF_TEST_CTRL, ADDR_LOGIC_SELF_TEST_CTRL: write_allowed = !l.selftest_lock_bit;
            ADDR_CHECK_CTRL, ADDR_DIAG_CTRL:  write_allowed = !l.control_lock_bit;
            ADDR_PWM_HMAX, ADDR_PWM_HMIN, ADDR_PWM_LMAX, ADDR_PWM_LMIN,
            ADDR_PWD_TH, ADDR_CFG_CRC,
            ADDR_WDT_WIN1, ADDR_WDT_WIN2, ADDR_WDT_QA_CFG:
                                              write_allowed = cfg_ok;
            ADDR_DIAG_MUX, ADDR_WDT_ANSWER:   write_allowed = 1'b1;
            default:                          write_allowed = 1'b0;
        endcase
    endfunction

    function automatic logic is_read(input spi_req_s r, input logic [ADDR_W-1:0] a);
        is_read = r.valid && !r.write && (r.addr == a);
    endfunction

    // simple byte sum; cheap and enough to catch a corrupted config byte
    function automatic logic [DATA_W-1:0] cfg_sum(input ctrl_s c);
        cfg_sum = DATA_W'(c.pwm_hmax + c.pwm_hmin + c.pwm_lmax + c.pwm_lmin + c.pwd_th
                          + c.wdt_win1 + c.wdt_win2 + c.wdt_qa_cfg);
    endfunction

    // ---------------- reinitialisation sources
    logic [CFG_W-1:0] watchdog_config_q;
    logic [CFG_W-1:0] watchdog_config_d;
    logic             cfg_primed_q;
    logic             cfg_primed_d;
    logic             watchdog_config_change;
    logic             wd_reinit_q;
    logic             wd_reinit_d;

    // no change is seen before the first sample after power-on
    assign watchdog_config_change = cfg_primed_q && (watchdog_config != watchdog_config_q);

    always_comb
    begin
        watchdog_config_d     = watchdog_config;
        cfg_primed_d = 1'b1;
        wd_reinit_d  = device_reset || logic_self_test_run || watchdog_config_change;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            watchdog_config_q     <= '0;
            cfg_primed_q <= 1'b0;
            wd_reinit_q  <= 1'b0;
        end
        else if (ce)
        begin
            watchdog_config_q     <= watchdog_config_d;
            cfg_primed_q <= cfg_primed_d;
            wd_reinit_q  <= wd_reinit_d;
        end
    end

    // ---------------- writable configuration and control
    logic                     wr_req;
    logic                     wr_ok;
    ctrl_s                    ctrl_q;
    ctrl_s                    ctrl_d;
    logic [DEVICE_ERROR_COUNTER_W-1:0] err_cnt_q;
    logic [DEVICE_ERROR_COUNTER_W-1:0] err_cnt_d;
    logic [DATA_W-1:0]        answer_q;
    logic [DATA_W-1:0]        answer_d;
    logic                     answer_stb_q;
    logic                     answer_stb_d;
    logic                     refused_q;
    logic                     refused_d;

    assign wr_req = req.valid && req.write;
    assign wr_ok  = wr_req && write_allowed(req.addr, locks);

    always_comb
    begin
        ctrl_d       = ctrl_q;
        err_cnt_d    = err_cnt_q;
        answer_d     = answer_q;
        answer_stb_d = 1'b0;
        refused_d    = wr_req && !wr_ok;
        // a refused write falls through every case below untouched
        if (wr_ok)
        begin
            unique case (req.addr)
                ADDR_ERR_STAT4:  err_cnt_d = req.wdata[DEVICE_ERROR_COUNTER_LSB +: DEVICE_ERROR_COUNTER_W];
                ADDR_ANALOG_SELF_TEST_CTRL: ctrl_d.analog_self_test_ctrl = req.wdata;
                ADDR_LOGIC_SELF_TEST_CTRL: ctrl_d.logic_self_test_ctrl = req.wdata;
                ADDR_CHECK_CTRL: ctrl_d.check_ctrl = req.wdata;
                ADDR_DIAG_CTRL:  ctrl_d.diag_ctrl = req.wdata;
                ADDR_PWM_HMAX:   ctrl_d.pwm_hmax = req.wdata;
                ADDR_PWM_HMIN:   ctrl_d.pwm_hmin = req.wdata;
                ADDR_PWM_LMAX:   ctrl_d.pwm_lmax = req.wdata;
                ADDR_PWM_LMIN:   ctrl_d.pwm_lmin = req.wdata;
                ADDR_PWD_TH:     ctrl_d.pwd_th = req.wdata;
                ADDR_CFG_CRC:    ctrl_d.configuration_checksum = req.wdata;
                ADDR_WDT_WIN1:   ctrl_d.wdt_win1 = req.wdata;
                ADDR_WDT_WIN2:   ctrl_d.wdt_win2 = req.wdata;
                ADDR_WDT_QA_CFG: ctrl_d.wdt_qa_cfg = req.wdata;
                ADDR_DIAG_MUX:   ctrl_d.diag_mux_sel = req.wdata;
                ADDR_WDT_ANSWER:
                begin
                    answer_d     = req.wdata;
                    answer_stb_d = 1'b1;
                end
                default:         ctrl_d = ctrl_q;
            endcase
        end
        else if (dev_err_inc)
            err_cnt_d = err_cnt_q + 1'b1;
        // reinitialisation beats a write landing in the same cycle
        if (watchdog_config_change || device_reset)
        begin
            ctrl_d.wdt_win1 = WIN1_INIT;
            ctrl_d.wdt_win2 = WIN2_INIT;
        end
        if (watchdog_config_change || device_reset || logic_self_test_run)
            ctrl_d.wdt_qa_cfg = QA_CFG_INIT;
        if (device_reset)
        begin
            ctrl_d.analog_self_test_ctrl   = CTRL_INIT;
            ctrl_d.logic_self_test_ctrl   = CTRL_INIT;
            ctrl_d.check_ctrl   = CTRL_INIT;
            ctrl_d.diag_ctrl    = CTRL_INIT;
            ctrl_d.diag_mux_sel = CTRL_INIT;
            answer_d            = ANSWER_INIT;
            answer_stb_d        = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= '{analog_self_test_ctrl: CTRL_INIT, logic_self_test_ctrl: CTRL_INIT, check_ctrl: CTRL_INIT,
                        diag_ctrl: CTRL_INIT, diag_mux_sel: CTRL_INIT, pwm_hmax: CTRL_INIT,
                        pwm_hmin: CTRL_INIT, pwm_lmax: CTRL_INIT, pwm_lmin: CTRL_INIT,
                        pwd_th: CTRL_INIT, configuration_checksum: CTRL_INIT,
                        wdt_win1: WIN1_INIT, wdt_win2: WIN2_INIT, wdt_qa_cfg: QA_CFG_INIT};
            err_cnt_q    <= '0;
            answer_q     <= ANSWER_INIT;
            answer_stb_q <= 1'b0;
            refused_q    <= 1'b0;
        end
        else if (ce)
        begin
            ctrl_q       <= ctrl_d;
            err_cnt_q    <= err_cnt_d;
            answer_q     <= answer_d;
            answer_stb_q <= answer_stb_d;
            refused_q    <= refused_d;
        end
    end

    // ---------------- watchdog question and status
    logic [DATA_W-1:0] question_q;
    logic [DATA_W-1:0] question_d;
    logic [WDS_W-1:0]  wd_status_q;
    logic [WDS_W-1:0]  wd_status_d;
    logic              wd_init;

    assign wd_init = device_reset || logic_self_test_run || watchdog_config_change;

    always_comb
    begin
        question_d  = question_q;
        wd_status_d = wd_status_in;
        // only the watchdog core loads the question; no write path exists
        if (wd_question_load)
            question_d = wd_question_in;
        if (wd_init)
        begin
            question_d  = QUESTION_INIT;
            wd_status_d = '0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            question_q  <= QUESTION_INIT;
            wd_status_q <= '0;
        end
        else if (ce)
        begin
            question_q  <= question_d;
            wd_status_q <= wd_status_d;
        end
    end

    // ---------------- latched status registers
    logic             diag_to_flag;
    logic [SPI_W-1:0] spi_flags;
    logic [OFF_W-1:0] off_flags;
    logic [SPI_W-1:0] spi_cond;

    // flags load only when a frame closes, so reads inside a frame see the last one
    assign spi_cond = spi_frame_done ? spi_frame_err : '0;

    sticky_flags #(.W(1)) u_err4_flags (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .init     (1'b0),
        .rd_clr   (is_read(req, ADDR_ERR_STAT4)),
        .cond     (diag_timeout_cond),
        .flags    (diag_to_flag)
    );

    sticky_flags #(.W(SPI_W)) u_spi_flags (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .init     (1'b0),
        .rd_clr   (is_read(req, ADDR_SPI_XFER)),
        .cond     (spi_cond),
        .flags    (spi_flags)
    );

    sticky_flags #(.W(OFF_W)) u_off_flags (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .init     (1'b0),
        .rd_clr   (is_read(req, ADDR_OFF_STAT)),
        .cond     (off_state_cond),
        .flags    (off_flags)
    );

    // ---------------- read path and checksum check
    logic [DATA_W-1:0] rd_data_q;
    logic [DATA_W-1:0] rd_data_d;
    logic              rd_valid_q;
    logic              rd_valid_d;
    logic              crc_bad_q;
    logic              crc_bad_d;
    logic [DATA_W-1:0] err4_val;

    // the three live bits on top follow their source, unlatched
    assign err4_val = {err4_live, diag_to_flag, err_cnt_q};

    always_comb
    begin
        rd_valid_d = req.valid && !req.write;
        rd_data_d  = rd_data_q;
        crc_bad_d  = cfg_sum(ctrl_q) != ctrl_q.configuration_checksum;
        if (rd_valid_d)
        begin
            unique case (req.addr)
                ADDR_ERR_STAT4:    rd_data_d = err4_val;
                ADDR_SPI_XFER:     rd_data_d = spi_flags;
                ADDR_ANALOG_SELF_TEST_CTRL:   rd_data_d = ctrl_q.analog_self_test_ctrl;
                ADDR_LOGIC_SELF_TEST_CTRL:   rd_data_d = ctrl_q.logic_self_test_ctrl;
                ADDR_CHECK_CTRL:   rd_data_d = ctrl_q.check_ctrl;
                ADDR_PWM_HMAX:     rd_data_d = ctrl_q.pwm_hmax;
                ADDR_PWM_HMIN:     rd_data_d = ctrl_q.pwm_hmin;
                ADDR_PWM_LMAX:     rd_data_d = ctrl_q.pwm_lmax;
                ADDR_PWM_LMIN:     rd_data_d = ctrl_q.pwm_lmin;
                ADDR_PWD_TH:       rd_data_d = ctrl_q.pwd_th;
                ADDR_CFG_CRC:      rd_data_d = ctrl_q.configuration_checksum;
                ADDR_DIAG_CTRL:    rd_data_d = ctrl_q.diag_ctrl;
                ADDR_DIAG_MUX:     rd_data_d = ctrl_q.diag_mux_sel;
                ADDR_WDT_WIN1:     rd_data_d = ctrl_q.wdt_win1;
                ADDR_WDT_WIN2:     rd_data_d = ctrl_q.wdt_win2;
                ADDR_WDT_QA_CFG:   rd_data_d = ctrl_q.wdt_qa_cfg;
                ADDR_WDT_QUESTION: rd_data_d = question_q;
                ADDR_WDT_STATUS:   rd_data_d = wd_status_q;
                ADDR_OFF_STAT:     rd_data_d = off_flags;
                default:           rd_data_d = UNMAPPED_VAL;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_q  <= UNMAPPED_VAL;
            rd_valid_q <= 1'b0;
            crc_bad_q  <= 1'b0;
        end
        else if (ce)
        begin
            rd_data_q  <= rd_data_d;
            rd_valid_q <= rd_valid_d;
            crc_bad_q  <= crc_bad_d;
        end
    end

    assign rd_data              = rd_data_q;
    assign rd_valid             = rd_valid_q;
    assign wr_refused           = refused_q;
    assign ctrl                 = ctrl_q;
    assign device_error_counter = err_cnt_q;
    assign wdt_answer           = answer_q;
    assign wdt_answer_stb       = answer_stb_q;
    assign wd_reinit            = wd_reinit_q;
    assign cfg_checksum_bad     = crc_bad_q;

endmodule // safety_diag_regs

// ==== sim/host_model.sv ====
`timescale 1ns/1ps
module host_model
    import safety_diag_pkg::*;
(
    input  wire logic              core_clk,
    output spi_req_s               req,
    input  wire logic [DATA_W-1:0] rd_data,
    input  wire logic              rd_valid,
    input  wire logic              wr_refused
);
    logic [DATA_W-1:0] last_rd;
    logic              last_vld;
    logic              last_ref;

    initial req = '0;

    // one frame per call; answers go out as plain writes to the answer register
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        req <= '{1'b1, w, a, d};
        @(posedge core_clk);
        // idle data shows the inverse, never the stale frame
        req <= '{1'b0, ~w, ~a, ~d};
        #1;
        last_rd  = rd_data;
        last_vld = rd_valid;
        last_ref = wr_refused;
    endtask
endmodule // host_model

// ==== sim/safety_diag_monitor.sv ====
`timescale 1ns/1ps
module safety_diag_monitor
    import safety_diag_pkg::*;
(
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     ce,
    input  wire spi_req_s                 req,
    input  wire lock_s                    locks,
    input  wire logic                     device_reset,
    input  wire logic                     logic_self_test_run,
    input  wire logic                     rd_valid,
    input  wire logic                     wr_refused,
    input  wire ctrl_s                    ctrl,
    input  wire logic [DEVICE_ERROR_COUNTER_W-1:0] device_error_counter,
    input  wire logic [DATA_W-1:0]        wdt_answer,
    input  wire logic                     wdt_answer_stb,
    input  wire logic                     wd_reinit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic                     tk;
    logic                     wr;
    logic                     open_cfg;
    logic [DEVICE_ERROR_COUNTER_W-1:0] cnt_w;
    assign tk       = ce && req.valid;
    assign wr       = tk && req.write;
    assign open_cfg = locks.diag_state && !locks.config_lock_bit;
    assign cnt_w    = req.wdata[DEVICE_ERROR_COUNTER_W-1:0];

    read_answer_a: assert property (tk && !req.write |=> rd_valid && !wr_refused)
        else $error("read not answered in one cycle");
    question_ro_a: assert property (wr && req.addr == ADDR_WDT_QUESTION |=> wr_refused)
        else $error("question write not refused");
    selftest_lock_a: assert property (wr && req.addr == ADDR_ANALOG_SELF_TEST_CTRL && locks.selftest_lock_bit && !device_reset
        |=> wr_refused && $stable(ctrl.analog_self_test_ctrl))
        else $error("locked self-test write took effect");
    control_lock_a: assert property (wr && req.addr == ADDR_CHECK_CTRL && locks.control_lock_bit && !device_reset
        |=> wr_refused && $stable(ctrl.check_ctrl))
        else $error("locked check control write took effect");
    config_lock_a: assert property (wr && req.addr == ADDR_PWM_HMAX && !open_cfg
        |=> wr_refused && $stable(ctrl.pwm_hmax))
        else $error("locked limit write took effect");
    mux_free_a: assert property (wr && req.addr == ADDR_DIAG_MUX && !device_reset
        |=> !wr_refused && ctrl.diag_mux_sel == $past(req.wdata))
        else $error("mux select write lost");
    counter_write_a: assert property (wr && req.addr == ADDR_ERR_STAT4 && open_cfg
        |=> device_error_counter == $past(cnt_w))
        else $error("error counter write lost");
    device_reinit_a: assert property (ce && device_reset
        |=> ctrl.wdt_win1 == WIN1_INIT && ctrl.diag_mux_sel == CTRL_INIT && wd_reinit)
        else $error("device reset did not reinit");
    selftest_reinit_a: assert property (ce && logic_self_test_run |=> ctrl.wdt_qa_cfg == QA_CFG_INIT && wd_reinit)
        else $error("self-test run did not reinit");
    answer_write_a: assert property (wr && req.addr == ADDR_WDT_ANSWER && !device_reset
        |=> wdt_answer_stb && wdt_answer == $past(req.wdata))
        else $error("answer not delivered");
    cover property (wr && wr_refused);
    cover property (ce && device_reset);
    cover property (tk && req.addr == ADDR_ERR_STAT4 ##1 rd_valid);
endmodule // safety_diag_monitor

bind safety_diag_regs safety_diag_monitor u_mon (.core_clk, .rst_n, .ce, .req, .locks, .device_reset,
    .logic_self_test_run, .rd_valid, .wr_refused, .ctrl, .device_error_counter, .wdt_answer, .wdt_answer_stb,
    .wd_reinit);

// ==== sim/safety_diag_regs_bench.sv ====
`timescale 1ns/1ps
module safety_diag_regs_bench
    import safety_diag_pkg::*;
;
    logic core_clk, rst_n, ce, device_reset, logic_self_test_run, diag_timeout_cond, dev_err_inc;
    logic spi_frame_done, wd_question_load, rd_valid, wr_refused, wdt_answer_stb, wd_reinit, cfg_checksum_bad;
    logic [7:0] watchdog_config, spi_frame_err, off_state_cond, wd_question_in, wd_status_in, rd_data, wdt_answer;
    logic [2:0] err4_live;
    logic [3:0] device_error_counter;
    spi_req_s   req;
    lock_s      locks;
    ctrl_s      ctrl;
    logic [7:0] shadow [0:63];
    int         error_cnt, checked, cycles;
    localparam lock_s OPEN = 4'b0001;

    host_model HOST (.core_clk, .req, .rd_data, .rd_valid, .wr_refused);
    safety_diag_regs DUT (.core_clk, .rst_n, .ce, .req, .locks, .device_reset, .logic_self_test_run,
        .watchdog_config, .diag_timeout_cond, .err4_live, .dev_err_inc, .spi_frame_done, .spi_frame_err,
        .off_state_cond, .wd_question_load, .wd_question_in, .wd_status_in, .rd_data, .rd_valid, .wr_refused,
        .ctrl, .device_error_counter, .wdt_answer, .wdt_answer_stb, .wd_reinit, .cfg_checksum_bad);

    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict;
        if (error_cnt == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            error_cnt++;
            print_verdict;
        end
    end

    function automatic bit allowed(logic [5:0] a, lock_s l);
        if (a inside {ADDR_ERR_STAT4, [ADDR_PWM_HMAX:ADDR_CFG_CRC], [ADDR_WDT_WIN1:ADDR_WDT_QA_CFG]})
            return l.diag_state && !l.config_lock_bit;
        if (a inside {ADDR_ANALOG_SELF_TEST_CTRL, ADDR_LOGIC_SELF_TEST_CTRL}) return !l.selftest_lock_bit;
        if (a inside {ADDR_CHECK_CTRL, ADDR_DIAG_CTRL}) return !l.control_lock_bit;
        return a inside {ADDR_DIAG_MUX, ADDR_WDT_ANSWER};
    endfunction

    function automatic logic [7:0] csum();
        return shadow[5] + shadow[6] + shadow[7] + shadow[8] + shadow[9] + shadow[13] + shadow[14] + shadow[15];
    endfunction

    // every access checks its handshake; every read checks data against the shadow
    task automatic rw(input logic w, input logic [5:0] a, input logic [7:0] d, input lock_s l);
        @(posedge core_clk);
        locks <= l;
        HOST.acc(w, a, d);
        if (w && allowed(a, l) && a != ADDR_WDT_ANSWER)
            shadow[a] = (a == ADDR_ERR_STAT4) ? {shadow[0][7:4], d[3:0]} : d;
        chk({6'h0, HOST.last_vld, HOST.last_ref}, {6'h0, !w, w && !allowed(a, l)});
        if (!w)
            chk(HOST.last_rd, shadow[a]);
    endtask

    initial begin
        {rst_n, device_reset, logic_self_test_run, diag_timeout_cond, dev_err_inc, spi_frame_done} = '0;
        {wd_question_load, watchdog_config, spi_frame_err, off_state_cond, wd_question_in, wd_status_in} = '0;
        {err4_live, locks} = '0;
        ce = 1'b1;
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        void'($urandom(75));
        #1 chk({7'h0, |ctrl}, 8'h00);
        repeat (300) rw($urandom_range(0, 1), $urandom_range(0, 21), $urandom, $urandom);
        rw(1, ADDR_WDT_QUESTION, 8'hFF, OPEN);
        @(posedge core_clk) diag_timeout_cond <= 1;
        @(posedge core_clk) diag_timeout_cond <= 0;
        shadow[0][4] = 1;
        rw(0, ADDR_ERR_STAT4, 0, OPEN);
        shadow[0][4] = 0;
        rw(0, ADDR_ERR_STAT4, 0, OPEN);
        @(posedge core_clk) diag_timeout_cond <= 1;
        shadow[0][4] = 1;
        repeat (2) rw(0, ADDR_ERR_STAT4, 0, OPEN);
        diag_timeout_cond <= 0;
        rw(0, ADDR_ERR_STAT4, 0, OPEN);
        shadow[0][4] = 0;
        rw(0, ADDR_ERR_STAT4, 0, OPEN);
        @(posedge core_clk) {spi_frame_done, spi_frame_err} <= 9'h1A5;
        @(posedge core_clk) {spi_frame_done, spi_frame_err} <= 9'h05A;
        shadow[1] = 8'hA5;
        rw(0, ADDR_SPI_XFER, 0, OPEN);
        shadow[1] = 8'h00;
        rw(0, ADDR_SPI_XFER, 0, OPEN);
        @(posedge core_clk) off_state_cond <= 8'h81;
        @(posedge core_clk) off_state_cond <= 8'h01;
        shadow[19] = 8'h81;
        rw(0, ADDR_OFF_STAT, 0, OPEN);
        shadow[19] = 8'h01;
        rw(0, ADDR_OFF_STAT, 0, OPEN);
        @(posedge core_clk) {wd_question_load, wd_question_in, wd_status_in, err4_live} <= {9'h15A, 8'h33, 3'h5};
        @(posedge core_clk) {wd_question_load, dev_err_inc} <= 2'b01;
        @(posedge core_clk) dev_err_inc <= 0;
        {shadow[16], shadow[17]} = 16'h5A33;
        shadow[0] = {3'h5, 1'b0, shadow[0][3:0] + 4'h1};
        rw(1, ADDR_WDT_QUESTION, 8'hFF, OPEN);
        foreach (shadow[i]) if (i inside {0, 16, 17}) rw(0, i, 0, OPEN);
        foreach (shadow[i]) if (i inside {2, 5, 12, 13, 14, 15}) rw(1, i, 8'h40 + i, OPEN);
        @(posedge core_clk) device_reset <= 1;
        @(posedge core_clk) device_reset <= 0;
        foreach (shadow[i]) if (i inside {2, 3, 4, 11, 12, 13, 14, 15}) shadow[i] = 8'h00;
        foreach (shadow[i]) if (i inside {2, 5, 12, 13}) rw(0, i, 0, OPEN);
        rw(1, ADDR_WDT_WIN1, 8'h66, OPEN);
        rw(1, ADDR_WDT_QA_CFG, 8'h77, OPEN);
        @(posedge core_clk) logic_self_test_run <= 1;
        @(posedge core_clk) logic_self_test_run <= 0;
        shadow[15] = 8'h00;
        rw(0, ADDR_WDT_QA_CFG, 0, OPEN);
        rw(0, ADDR_WDT_WIN1, 0, OPEN);
        @(posedge core_clk) watchdog_config <= 8'h01;
        shadow[13] = 8'h00;
        rw(0, ADDR_WDT_WIN1, 0, OPEN);
        rw(1, ADDR_WDT_ANSWER, 8'hC3, OPEN);
        chk(wdt_answer, 8'hC3);
        ce <= 1'b0;
        rw(1, ADDR_DIAG_MUX, 8'h99, OPEN);
        ce <= 1'b1;
        shadow[12] = 8'h00;
        rw(0, ADDR_DIAG_MUX, 0, OPEN);
        rw(1, ADDR_WDT_WIN2, 8'h21, OPEN);
        rw(1, ADDR_CFG_CRC, csum(), OPEN);
        repeat (2) @(posedge core_clk);
        #1 chk({7'h0, cfg_checksum_bad}, 8'h00);
        rw(1, ADDR_WDT_WIN2, 8'h22, OPEN);
        repeat (2) @(posedge core_clk);
        #1 chk({7'h0, cfg_checksum_bad}, 8'h01);
        print_verdict;
    end
endmodule // safety_diag_regs_bench
